// [core/atx_core.sv]
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "atx_consts.svh"

// What this block does
// - 32-bit accumulator; byte uses bits 7:0, word 15:0, long all 32.
// - Byte load: zero fill clears bits 15:8; no transfer keeps them.
// - Byte load with extension sign-extends the byte into bits 15:8.
// - High half: copy old low half, keep, clear, or sign-extend low half.
// - Seven flags each updated (N, Z from result, others from flag_in), forced set, cleared, or kept.
// - Short I/O form reaches only physical 000000 through 0000FF.
// - Execution cycles equal base count plus operand-dependent correction.
// - Active stack pointer and bank follow the stack select flag.
// - Physical address is 24 bits; bits 15:0 and 23:16 are separate fields.
// - Address codes 00 to 07 select registers by operand type.
module atx_core (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Avalon-MM slave
   input wire atx_pkg::atx_avs_req_t avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Status
   output logic [31:0] acc_out,
   output logic [6:0] flags_out
);
   import atx_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [15:0] sext8(input logic [7:0] v);
      return {{8{v[7]}}, v};
   endfunction

   function automatic logic [15:0] sext16_hi(input logic [15:0] v);
      return {16{v[15]}};
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Correction per operand class and size
   function automatic logic [2:0] corr(input logic [2:0] cls, input atx_size_t sz);
      logic [2:0] b;
      logic [2:0] w;
      logic [2:0] l;
      b = 3'h0;
      w = 3'h0;
      l = 3'h0;
      unique case (cls)
         3'h2: begin
            w = 3'h1;
            l = 3'h2;
         end
         3'h3: begin
            b = 3'h1;
            w = 3'h1;
            l = 3'h2;
         end
         3'h4, 3'h5: begin
            b = 3'h1;
            w = 3'h3;
            l = 3'h6;
         end
         default: begin
            b = 3'h0;
         end
      endcase
      unique case (sz)
         SZ_BYTE: return b;
         SZ_WORD: return w;
         default: return l;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [31:0] acc_reg, acc_next;
   logic [6:0] flags_reg, flags_next;
   logic [31:0] operand_reg, operand_next;
   logic [15:0] usr_sp_reg, usr_sp_next;
   logic [15:0] sys_sp_reg, sys_sp_next;
   logic [7:0] usb_reg, usb_next;
   logic [7:0] sys_bank_reg, sys_bank_next;
   logic [15:0] addr_lo_reg, addr_lo_next;
   logic [7:0] addr_bank_reg, addr_bank_next;
   atx_cyc_t cyc_reg, cyc_next;
   logic [15:0] regs_reg [8];
   logic [15:0] regs_next [8];

   ////////////////////////////////////////////////////////////////////
   // Derived values
   atx_cmd_t cmd;
   logic [31:0] src, res;
   logic [15:0] act_sp;
   logic [7:0] cur_bank;
   logic [23:0] phys;
   logic io_hit;
   logic [8:0] cyc_total;
   logic [2:0] widx;
   logic [1:0] lidx;
   logic [31:0] wmerged;
   logic [6:0] upd;
   logic do_wr, do_rd;

   assign do_wr = avs_req.write & ack_reg;
   assign do_rd = avs_req.read & ~ack_reg;
   assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_reg;
   assign avs_readdata = rdata_reg;
   assign acc_out = acc_reg;
   assign flags_out = flags_reg;

   assign act_sp = flags_reg[`ATX_FLAG_S] ? sys_sp_reg : usr_sp_reg;
   assign cur_bank = flags_reg[`ATX_FLAG_S] ? sys_bank_reg : usb_reg;
   assign phys = {addr_bank_reg, addr_lo_reg};
   assign io_hit = (phys >= `ATX_IO_LO) && (phys <= `ATX_IO_HI);
   assign cyc_total = {1'b0, cyc_reg.base}
                      + {6'h00, corr(cyc_reg.opnd_class, cyc_reg.size)};

   ////////////////////////////////////////////////////////////////////
   // Command datapath
   always_comb begin
      cmd = atx_cmd_t'(avs_req.writedata);
      widx = cmd.restricted ? {1'b0, cmd.ea[1:0]} : cmd.ea;
      lidx = cmd.ea[2:1];
      unique case (cmd.size)
         SZ_BYTE: src = {24'h00_0000, regs_reg[cmd.ea][7:0]};
         SZ_WORD: src = {16'h0000, regs_reg[widx]};
         default: src = {regs_reg[{lidx, 1'b1}], regs_reg[{lidx, 1'b0}]};
      endcase
      if (!cmd.src_reg) begin
         src = operand_reg;
      end
      res = acc_reg;
      unique case (cmd.size)
         SZ_BYTE: begin
            res[7:0] = src[7:0];
            unique case (cmd.lub_fill)
               LUB_ZERO: res[15:8] = 8'h00;
               LUB_EXT: res[15:0] = sext8(src[7:0]);
               default: res[15:8] = acc_reg[15:8];
            endcase
         end
         SZ_WORD: res[15:0] = src[15:0];
         default: res = src;
      endcase
      if (cmd.size != SZ_LONG) begin
         unique case (cmd.hi_fill)
            HI_COPY: res[31:16] = acc_reg[15:0];
            HI_ZERO: res[31:16] = 16'h0000;
            HI_EXT: res[31:16] = sext16_hi(res[15:0]);
            default: res[31:16] = acc_reg[31:16];
         endcase
      end
      if (cmd.store) begin
         res = acc_reg;
      end
      upd[`ATX_FLAG_C] = cmd.flag_in[0];
      upd[`ATX_FLAG_V] = cmd.flag_in[1];
      upd[`ATX_FLAG_T] = cmd.flag_in[2];
      upd[`ATX_FLAG_S] = cmd.flag_in[3];
      upd[`ATX_FLAG_I] = cmd.flag_in[4];
      unique case (cmd.size)
         SZ_BYTE: begin
            upd[`ATX_FLAG_N] = res[7];
            upd[`ATX_FLAG_Z] = (res[7:0] == 8'h00);
         end
         SZ_WORD: begin
            upd[`ATX_FLAG_N] = res[15];
            upd[`ATX_FLAG_Z] = (res[15:0] == 16'h0000);
         end
         default: begin
            upd[`ATX_FLAG_N] = res[31];
            upd[`ATX_FLAG_Z] = (res == 32'h0000_0000);
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      ack_next = (avs_req.read | avs_req.write) & ~ack_reg;
      rdata_next = rdata_reg;
      acc_next = acc_reg;
      flags_next = flags_reg;
      operand_next = operand_reg;
      usr_sp_next = usr_sp_reg;
      sys_sp_next = sys_sp_reg;
      usb_next = usb_reg;
      sys_bank_next = sys_bank_reg;
      addr_lo_next = addr_lo_reg;
      addr_bank_next = addr_bank_reg;
      cyc_next = cyc_reg;
      regs_next = regs_reg;
      wmerged = 32'h0000_0000;
      if (do_rd) begin
         unique case (avs_req.address)
            `ATX_OPERAND_OFS: rdata_next = operand_reg;
            `ATX_ACC_LO_OFS: rdata_next = {16'h0000, acc_reg[15:0]};
            `ATX_ACC_HI_OFS: rdata_next = {16'h0000, acc_reg[31:16]};
            `ATX_FLAGS_OFS: rdata_next = {25'h000_0000, flags_reg};
            `ATX_USR_SP_OFS: rdata_next = {16'h0000, usr_sp_reg};
            `ATX_SYS_SP_OFS: rdata_next = {16'h0000, sys_sp_reg};
            `ATX_BANKS_OFS: rdata_next = {16'h0000, sys_bank_reg, usb_reg};
            `ATX_ACT_STACK_OFS: rdata_next = {8'h00, cur_bank, act_sp};
            `ATX_ADDR_LO_OFS: rdata_next = {16'h0000, addr_lo_reg};
            `ATX_ADDR_BANK_OFS: rdata_next = {24'h00_0000, addr_bank_reg};
            `ATX_ADDR_INFO_OFS: rdata_next = {7'h00, io_hit, phys};
            `ATX_CYC_CFG_OFS: rdata_next = cyc_reg;
            `ATX_CYC_TOTAL_OFS: rdata_next = {23'h00_0000, cyc_total};
            default: begin
               if (avs_req.address >= `ATX_REGS_OFS && avs_req.address <= `ATX_REGS_END
                   && avs_req.address[1:0] == 2'b00) begin
                  rdata_next = {16'h0000, regs_reg[avs_req.address[4:2]]};
               end else begin
                  rdata_next = 32'h0000_0000;
               end
            end
         endcase
      end
      if (do_wr) begin
         unique case (avs_req.address)
            `ATX_CMD_OFS: begin
               acc_next = res;
               if (cmd.store) begin
                  unique case (cmd.size)
                     SZ_BYTE: regs_next[cmd.ea][7:0] = acc_reg[7:0];
                     SZ_WORD: regs_next[widx] = acc_reg[15:0];
                     default: begin
                        regs_next[{lidx, 1'b0}] = acc_reg[15:0];
                        regs_next[{lidx, 1'b1}] = acc_reg[31:16];
                     end
                  endcase
               end
               for (int k = 0; k < 7; k++) begin
                  unique case (atx_fact_t'(cmd.flag_act[k*2 +: 2]))
                     FA_UPD: flags_next[k] = upd[k];
                     FA_SET: flags_next[k] = 1'b1;
                     FA_CLR: flags_next[k] = 1'b0;
                     default: flags_next[k] = flags_reg[k];
                  endcase
               end
            end
            `ATX_OPERAND_OFS: begin
               operand_next = be_merge(operand_reg, avs_req.writedata, avs_req.byteenable);
            end
            `ATX_ACC_LO_OFS: begin
               wmerged = be_merge({16'h0000, acc_reg[15:0]}, avs_req.writedata,
                                  avs_req.byteenable);
               acc_next[15:0] = wmerged[15:0];
            end
            `ATX_ACC_HI_OFS: begin
               wmerged = be_merge({16'h0000, acc_reg[31:16]}, avs_req.writedata,
                                  avs_req.byteenable);
               acc_next[31:16] = wmerged[15:0];
            end
            `ATX_FLAGS_OFS: begin
               if (avs_req.byteenable[0]) begin
                  flags_next = avs_req.writedata[6:0];
               end
            end
            `ATX_USR_SP_OFS: begin
               wmerged = be_merge({16'h0000, usr_sp_reg}, avs_req.writedata,
                                  avs_req.byteenable);
               usr_sp_next = wmerged[15:0];
            end
            `ATX_SYS_SP_OFS: begin
               wmerged = be_merge({16'h0000, sys_sp_reg}, avs_req.writedata,
                                  avs_req.byteenable);
               sys_sp_next = wmerged[15:0];
            end
            `ATX_BANKS_OFS: begin
               wmerged = be_merge({16'h0000, sys_bank_reg, usb_reg}, avs_req.writedata,
                                  avs_req.byteenable);
               usb_next = wmerged[7:0];
               sys_bank_next = wmerged[15:8];
            end
            `ATX_ADDR_LO_OFS: begin
               wmerged = be_merge({16'h0000, addr_lo_reg}, avs_req.writedata,
                                  avs_req.byteenable);
               addr_lo_next = wmerged[15:0];
            end
            `ATX_ADDR_BANK_OFS: begin
               if (avs_req.byteenable[0]) begin
                  addr_bank_next = avs_req.writedata[7:0];
               end
            end
            `ATX_CYC_CFG_OFS: begin
               cyc_next = be_merge(cyc_reg, avs_req.writedata, avs_req.byteenable);
               cyc_next.rsvd = 19'h0_0000;
            end
            default: begin
               if (avs_req.address >= `ATX_REGS_OFS && avs_req.address <= `ATX_REGS_END
                   && avs_req.address[1:0] == 2'b00) begin
                  wmerged = be_merge({16'h0000, regs_reg[avs_req.address[4:2]]},
                                     avs_req.writedata, avs_req.byteenable);
                  regs_next[avs_req.address[4:2]] = wmerged[15:0];
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         acc_reg <= `ATX_ACC_RST;
         flags_reg <= `ATX_FLAGS_RST;
         operand_reg <= 32'h0000_0000;
         usr_sp_reg <= 16'h0000;
         sys_sp_reg <= 16'h0000;
         usb_reg <= 8'h00;
         sys_bank_reg <= 8'h00;
         addr_lo_reg <= 16'h0000;
         addr_bank_reg <= 8'h00;
         cyc_reg <= '0;
         for (int i = 0; i < 8; i++) begin
            regs_reg[i] <= 16'h0000;
         end
      end else begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         operand_reg <= operand_next;
         usr_sp_reg <= usr_sp_next;
         sys_sp_reg <= sys_sp_next;
         usb_reg <= usb_next;
         sys_bank_reg <= sys_bank_next;
         addr_lo_reg <= addr_lo_next;
         addr_bank_reg <= addr_bank_next;
         cyc_reg <= cyc_next;
         regs_reg <= regs_next;
      end
   end
endmodule

// [core/atx_consts.svh]
`ifndef ATX_CONSTS_SVH
`define ATX_CONSTS_SVH
// Register byte offsets
`define ATX_CMD_OFS 8'h00
`define ATX_OPERAND_OFS 8'h04
`define ATX_ACC_LO_OFS 8'h08
`define ATX_ACC_HI_OFS 8'h0C
`define ATX_FLAGS_OFS 8'h10
`define ATX_USR_SP_OFS 8'h14
`define ATX_SYS_SP_OFS 8'h18
`define ATX_BANKS_OFS 8'h1C
`define ATX_ACT_STACK_OFS 8'h20
`define ATX_ADDR_LO_OFS 8'h24
`define ATX_ADDR_BANK_OFS 8'h28
`define ATX_ADDR_INFO_OFS 8'h2C
`define ATX_CYC_CFG_OFS 8'h30
`define ATX_CYC_TOTAL_OFS 8'h34
`define ATX_REGS_OFS 8'h40
`define ATX_REGS_END 8'h5C
// Flag bit positions
`define ATX_FLAG_C 0
`define ATX_FLAG_V 1
`define ATX_FLAG_Z 2
`define ATX_FLAG_N 3
`define ATX_FLAG_T 4
`define ATX_FLAG_S 5
`define ATX_FLAG_I 6
// Reset values
`define ATX_FLAGS_RST 7'h00
`define ATX_ACC_RST 32'h0000_0000
// Short I/O region bounds
`define ATX_IO_LO 24'h00_0000
`define ATX_IO_HI 24'h00_00FF
`endif

// [core/atx_pkg.sv]
package atx_pkg;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_RSVD} atx_size_t;
   typedef enum logic [1:0] {LUB_NONE, LUB_ZERO, LUB_EXT, LUB_RSVD} atx_lub_fill_t;
   typedef enum logic [1:0] {HI_NONE, HI_COPY, HI_ZERO, HI_EXT} atx_hi_fill_t;
   typedef enum logic [1:0] {FA_KEEP, FA_UPD, FA_SET, FA_CLR} atx_fact_t;
   typedef struct packed {
      logic rsvd;
      logic [4:0] flag_in;
      logic [13:0] flag_act;
      logic restricted;
      logic store;
      logic [2:0] ea;
      logic src_reg;
      atx_hi_fill_t hi_fill;
      atx_lub_fill_t lub_fill;
      atx_size_t size;
   } atx_cmd_t;
   typedef struct packed {
      logic [18:0] rsvd;
      atx_size_t size;
      logic [2:0] opnd_class;
      logic [7:0] base;
   } atx_cyc_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } atx_avs_req_t;
endpackage

// [testbench/atx_core_asserts.sv]
`timescale 1ns/1ps
module atx_core_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Bus
   input wire atx_pkg::atx_avs_req_t avs_req,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Status
   input wire logic [31:0] acc_out,
   input wire logic [6:0] flags_out
);
   import atx_pkg::*;
   atx_cmd_t cmd;
   logic [31:0] opnd_reg;
   logic [31:0] opnd_next;
   assign cmd = atx_cmd_t'(avs_req.writedata);
   // Operand shadow
   always_comb begin
      opnd_next = opnd_reg;
      if (avs_req.write && !avs_waitrequest && avs_req.address == 8'h04) begin
         opnd_next = avs_req.writedata;
      end
   end
   always_ff @(posedge ref_clk) begin
      opnd_reg <= rstn ? opnd_next : 32'h0;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_done(logic [7:0] a);
      avs_req.write && !avs_waitrequest && avs_req.address == a;
   endsequence
   sequence s_load(atx_size_t sz);
      s_done(8'h00) ##0 (cmd.size == sz && !cmd.store && !cmd.src_reg);
   endsequence
   property p_lo_write;
      s_done(8'h08) ##0 (avs_req.byteenable == 4'hF) |=> acc_out[15:0] ==
         $past(avs_req.writedata[15:0]) && acc_out[31:16] == $past(acc_out[31:16]);
   endproperty
   property p_acc_hold;
      $changed(acc_out) |-> $past(avs_req.write && !avs_waitrequest);
   endproperty
   property p_flag_write;
      s_done(8'h10) |=> flags_out == $past(avs_req.writedata[6:0]);
   endproperty
   property p_flag_hold;
      $changed(flags_out) |-> $past(avs_req.write && !avs_waitrequest);
   endproperty
   property p_zero_fill;
      s_load(SZ_BYTE) ##0 (cmd.lub_fill == LUB_ZERO) |=>
         acc_out[15:0] == {8'h00, opnd_reg[7:0]};
   endproperty
   property p_keep_fill;
      s_load(SZ_BYTE) ##0 (cmd.lub_fill == LUB_NONE) |=>
         acc_out[15:8] == $past(acc_out[15:8]);
   endproperty
   property p_byte_ext;
      s_load(SZ_BYTE) ##0 (cmd.lub_fill == LUB_EXT) |=>
         acc_out[15:0] == {{8{opnd_reg[7]}}, opnd_reg[7:0]};
   endproperty
   property p_hi_copy;
      s_load(SZ_WORD) ##0 (cmd.hi_fill == HI_COPY) |=>
         acc_out[31:16] == $past(acc_out[15:0]);
   endproperty
   property p_hi_zero;
      s_load(SZ_WORD) ##0 (cmd.hi_fill == HI_ZERO) |=> acc_out[31:16] == 16'h0000;
   endproperty
   property p_word_ext;
      s_load(SZ_WORD) ##0 (cmd.hi_fill == HI_EXT) |=> acc_out[31:16] == {16{opnd_reg[15]}};
   endproperty
   property p_one_wait;
      $rose(avs_req.read || avs_req.write) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   property p_io_hit;
      avs_req.read && !avs_waitrequest && avs_req.address == 8'h2C |->
         avs_readdata[24] == (avs_readdata[23:8] == 16'h0000);
   endproperty
   a_lo_write: assert property (p_lo_write)
      else $error("low half write lost");
   a_acc_hold: assert property (p_acc_hold)
      else $error("accumulator moved without write");
   a_flag_write: assert property (p_flag_write)
      else $error("flag write lost");
   a_flag_hold: assert property (p_flag_hold)
      else $error("flags moved without write");
   a_zero_fill: assert property (p_zero_fill)
      else $error("zero fill wrong");
   a_keep_fill: assert property (p_keep_fill)
      else $error("kept byte changed");
   a_byte_ext: assert property (p_byte_ext)
      else $error("byte extension wrong");
   a_hi_copy: assert property (p_hi_copy)
      else $error("high copy wrong");
   a_hi_zero: assert property (p_hi_zero)
      else $error("high clear wrong");
   a_word_ext: assert property (p_word_ext)
      else $error("word extension wrong");
   a_io_hit: assert property (p_io_hit)
      else $error("io flag wrong");
   a_one_wait: assert property (p_one_wait)
      else $error("wait state count wrong");
endmodule

bind atx_core atx_core_chk chk_u (.ref_clk(ref_clk), .rstn(rstn), .avs_req(avs_req),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_out(acc_out),
   .flags_out(flags_out));

// [testbench/atx_core_test.sv]
`timescale 1ns/1ps
module atx_core_test;
   import atx_pkg::*;
   typedef struct {
      logic [6:0] f0;
      logic [31:0] op;
      logic [31:0] cmd;
      logic [31:0] acc;
      logic [6:0] fl;
   } atx_row_t;
   localparam logic [31:0] op_a = 32'hCAFE8A9B;
   logic ref_clk;
   logic rstn;
   atx_avs_req_t avs_req;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] acc_out;
   logic [6:0] flags_out;
   logic [31:0] rd;
   int num_errors = 0;
   int checks = 0;
   // Start flags, operand, command, result
   atx_row_t rows [17] = '{
      '{7'h00, op_a, 32'h000, 32'h1234569B, 7'h00},
      '{7'h00, op_a, 32'h004, 32'h1234009B, 7'h00},
      '{7'h00, op_a, 32'h50008, 32'h1234FF9B, 7'h08},
      '{7'h00, op_a, 32'h001, 32'h12348A9B, 7'h00},
      '{7'h00, op_a, 32'h011, 32'h56788A9B, 7'h00},
      '{7'h00, op_a, 32'h021, 32'h00008A9B, 7'h00},
      '{7'h00, op_a, 32'h031, 32'hFFFF8A9B, 7'h00},
      '{7'h00, op_a, 32'h002, 32'hCAFE8A9B, 7'h00},
      '{7'h00, op_a, 32'h038, 32'hFFFFFF9B, 7'h00},
      '{7'h00, 32'h7F, 32'h008, 32'h1234007F, 7'h00},
      '{7'h00, 32'hABCD0000, 32'h50001, 32'h12340000, 7'h04},
      '{7'h7F, op_a, 32'h20D002, 32'hCAFE8A9B, 7'h7C},
      '{7'h00, op_a, 32'h22400001, 32'h12348A9B, 7'h60},
      '{7'h00, op_a, 32'h1C0, 32'h12345603, 7'h00},
      '{7'h00, op_a, 32'h2C1, 32'h12341105, 7'h00},
      '{7'h00, op_a, 32'h2C2, 32'h11051104, 7'h00},
      '{7'h00, op_a, 32'hB41, 32'h12341102, 7'h00}};
   // Cycle corrections by class, then byte, word, long
   int corr [8][3] = '{'{0, 0, 0}, '{0, 0, 0}, '{0, 1, 2}, '{1, 1, 2},
      '{1, 3, 6}, '{1, 3, 6}, '{0, 0, 0}, '{0, 0, 0}};

   atx_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .avs_req(avs_req),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .acc_out(acc_out), .flags_out(flags_out));

   ////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_req.read <= !wr;
      avs_req.write <= wr;
      avs_req.address <= a;
      avs_req.writedata <= d;
      avs_req.byteenable <= 4'hF;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
   endtask

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(nm, e, rd);
   endtask

   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      stop_test();
   end

   initial begin
      rstn = 1'b0;
      avs_req = '0;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      check("acc reset", 32'h0, acc_out);
      check("flags reset", 32'h0, {25'h0, flags_out});
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 8'(8'h40 + i * 4), 32'(32'h1100 + i));
      end
      foreach (rows[i]) begin
         bus(1'b1, 8'h08, 32'h5678);
         bus(1'b1, 8'h0C, 32'h1234);
         bus(1'b1, 8'h10, {25'h0, rows[i].f0});
         bus(1'b1, 8'h04, rows[i].op);
         bus(1'b1, 8'h00, rows[i].cmd);
         @(negedge ref_clk);
         check("acc", rows[i].acc, acc_out);
         check("flags", {25'h0, rows[i].fl}, {25'h0, flags_out});
      end
      // Store word to register seven
      bus(1'b1, 8'h00, 32'h781);
      rdchk("store", 8'h5C, 32'h1102);
      rdchk("acc high", 8'h0C, 32'h1234);
      bus(1'b1, 8'h14, 32'h1111);
      bus(1'b1, 8'h18, 32'h2222);
      bus(1'b1, 8'h1C, 32'h5A3C);
      bus(1'b1, 8'h10, 32'h00);
      rdchk("user stack", 8'h20, 32'h003C1111);
      bus(1'b1, 8'h10, 32'h20);
      rdchk("system stack", 8'h20, 32'h005A2222);
      bus(1'b1, 8'h28, 32'h00);
      bus(1'b1, 8'h24, 32'h00FF);
      rdchk("io edge", 8'h2C, 32'h010000FF);
      bus(1'b1, 8'h24, 32'h0100);
      rdchk("io out", 8'h2C, 32'h00000100);
      bus(1'b1, 8'h28, 32'h12);
      rdchk("bank field", 8'h2C, 32'h00120100);
      bus(1'b1, 8'h2C, 32'hFFFFFFFF);
      rdchk("read only", 8'h2C, 32'h00120100);
      bus(1'b1, 8'h3C, 32'hFFFFFFFF);
      rdchk("unmapped", 8'h3C, 32'h0);
      for (int c = 0; c < 8; c++) begin
         for (int s = 0; s < 3; s++) begin
            bus(1'b1, 8'h30, {19'h0, 2'(s), 3'(c), 8'hFF});
            rdchk("cycles", 8'h34, 32'(255 + corr[c][s]));
         end
      end
      // Reset in mid run
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      @(negedge ref_clk);
      check("acc mid reset", 32'h0, acc_out);
      check("flags mid reset", 32'h0, {25'h0, flags_out});
      stop_test();
   end
endmodule
